// >>> hdl/mrc_pkg.sv
// constants and types shared by the reset controller
//
// Functional notes
// - power-on clears program counter, sets port data and direction registers high.
// - power-on or low-voltage reset holds the core for a 50 ms delay.
// - external reset pin acts as reset only when the option selects it.
// - core stays in reset while the pin is low, then starts at zero.
// - pin release or run-mode watchdog timeout adds a 16.7 ms delay.
// - supervisor is enabled outside power-down and resets the device on valid low supply.
// - low-supply pulses not longer than the qualification time are ignored.
// - supervisor is disabled while the device is powered down.
// - level select decodes four valid patterns 55, 33, 99 and aa.
// - invalid level pattern resets after 2-3 sub clocks and restores the register.
// - genuine low-voltage reset acts after 2-3 sub clocks, register kept.
// - level select register is 0x55 after power-on.
// - low-voltage cause flag set by that reset, cleared only by writing 0.
// - select-fault flag set on undefined pattern, cleared only by writing 0.
// - run-mode watchdog timeout resets like the pin and sets the timeout flag.
// - sleep or idle watchdog timeout clears only program counter and stack pointer.
// - start-up wait is 15-16, 1024 or 1-2 clocks by oscillator source.
// - timeout and power-down flags are updated by reset type.
// - power-on disables all interrupts and turns off all timer modules.
// - power-on clears watchdog and time base, stack pointer to top.
// - watchdog-control fault flag set on that reset, cleared only by writing 0.
package mrc_pkg;
    // ****************************************************
    // register map
    // ****************************************************
    localparam logic [7:0] LVL_SEL_ADDR = 8'h00;
    localparam logic [7:0] RST_FLAGS_ADDR = 8'h04;
    localparam logic [7:0] STATUS_ADDR = 8'h08;
    localparam logic [7:0] CONFIG_ADDR = 8'h0c;
    localparam logic [7:0] LVL_SEL_RESET = 8'h55;
    localparam logic [7:0] LVL_2V10 = 8'h55;
    localparam logic [7:0] LVL_2V55 = 8'h33;
    localparam logic [7:0] LVL_3V15 = 8'h99;
    localparam logic [7:0] LVL_3V80 = 8'haa;
    localparam int FLAG_SYSCLK_ON = 7;
    localparam int FLAG_LV_CAUSE = 2;
    localparam int FLAG_SEL_FAULT = 1;
    localparam int FLAG_WDT_FAULT = 0;
    localparam int CFG_PIN_RESET_EN = 0;
    localparam int CFG_OSC_LSB = 1;
    // ****************************************************
    // timing
    // ****************************************************
    localparam real CLK_MHZ = 250.0;
    localparam real POR_DELAY_MS = 50.0;
    localparam real PIN_DELAY_MS = 16.7;
    localparam int POR_DELAY_CYC = int'(POR_DELAY_MS * CLK_MHZ * 1000.0);
    localparam int PIN_DELAY_CYC = int'(PIN_DELAY_MS * CLK_MHZ * 1000.0);
    localparam int SST_RC_CYC = 16;
    localparam int SST_XTAL_CYC = 1024;
    localparam int SST_SLOW_CYC = 2;
    localparam int SUB_RESET_TICKS = 2;
    localparam int LV_QUAL_CYC = 64;
    localparam logic [2:0] OSC_EXT_RC = 3'h0;
    localparam logic [2:0] OSC_FAST_RC = 3'h1;
    localparam logic [2:0] OSC_FAST_XTAL = 3'h2;
    localparam logic [2:0] OSC_SLOW_XTAL = 3'h3;
    localparam logic [2:0] OSC_SLOW_RC = 3'h4;
    localparam logic [7:0] PORT_RESET = 8'hff;
    typedef enum logic [1:0] {MRC_RUN, MRC_HOLD, MRC_DELAY} mrc_state_t;
endpackage : mrc_pkg

// >>> hdl/mrc_reset_ctrl.sv
// reset source merging, delays, cause flags and level-select guard
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl
    import mrc_pkg::*;
#(
    parameter int POR_CYC = POR_DELAY_CYC,
    parameter int PIN_CYC = PIN_DELAY_CYC,
    parameter int QUAL_CYC = LV_QUAL_CYC
) (
    // clock and power-on reset
    input wire logic CLK_SYS_I,
    input wire logic RST_I,
    // reset sources
    input wire logic EXT_RESET_PIN_N_I,
    input wire logic LV_LOW_SUPPLY_I,
    input wire logic WDT_TIMEOUT_I,
    input wire logic WDT_CTRL_FAULT_I,
    input wire logic SUB_CLOCK_TICK_I,
    input wire logic POWERDOWN_I,
    input wire logic IDLE_I,
    // apb
    input wire logic PSEL_I,
    input wire logic PENABLE_I,
    input wire logic PWRITE_I,
    input wire logic [7:0] PADDR_I,
    input wire logic [31:0] PWDATA_I,
    output logic [31:0] PRDATA_O,
    output logic PREADY_O,
    output logic PSLVERR_O,
    // core controls
    output logic CORE_RESET_O,
    output logic FULL_RESET_O,
    output logic PC_SP_CLEAR_O,
    output logic POR_INIT_O,
    output logic [7:0] PORT_INIT_O,
    output logic WATCHDOG_TIMEOUT_FLAG_O,
    output logic POWERDOWN_FLAG_O,
    output logic [7:0] LV_LEVEL_SELECT_O,
    output logic EXT_RESET_PIN_IS_IO_O
);
    // ****************************************************
    // registers and decode
    // ****************************************************
    mrc_state_t state;
    logic [27:0] count;
    logic [7:0] lv_level_select;
    logic [7:0] flags;
    logic [3:0] cfg;
    logic [7:0] qual_cnt;
    logic [1:0] sub_cnt;
    logic lv_pending;
    logic sel_pending;
    logic por_done;
    logic pin_held;
    logic lv_fire;
    logic sel_fire;
    logic wdt_run;
    logic wdt_sleep;
    logic pin_low;
    logic valid_sel;
    logic wr;
    logic rd;

    function automatic logic level_ok(input logic [7:0] v);
        level_ok = (v == LVL_2V10) || (v == LVL_2V55) || (v == LVL_3V15) || (v == LVL_3V80);
    endfunction : level_ok

    function automatic logic [27:0] sst_cycles(input logic [2:0] osc);
        case (osc)
            OSC_EXT_RC, OSC_FAST_RC: sst_cycles = 28'(SST_RC_CYC);
            OSC_FAST_XTAL, OSC_SLOW_XTAL: sst_cycles = 28'(SST_XTAL_CYC);
            default: sst_cycles = 28'(SST_SLOW_CYC);
        endcase
    endfunction : sst_cycles

    assign valid_sel = level_ok(lv_level_select);
    assign wr = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd = PSEL_I && !PWRITE_I;
    assign pin_low = cfg[CFG_PIN_RESET_EN] && !EXT_RESET_PIN_N_I;
    assign lv_fire = lv_pending && SUB_CLOCK_TICK_I && (sub_cnt == 2'(SUB_RESET_TICKS));
    assign sel_fire = sel_pending && SUB_CLOCK_TICK_I && (sub_cnt == 2'(SUB_RESET_TICKS));
    assign wdt_run = WDT_TIMEOUT_I && !POWERDOWN_I && !IDLE_I && state == MRC_RUN;
    assign wdt_sleep = WDT_TIMEOUT_I && (POWERDOWN_I || IDLE_I) && state == MRC_RUN;

    // ****************************************************
    // low-supply qualification
    // ****************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || POWERDOWN_I || !LV_LOW_SUPPLY_I) begin
            qual_cnt <= 8'h00;
        end else if (qual_cnt <= 8'(QUAL_CYC)) begin
            qual_cnt <= qual_cnt + 8'h01;
        end
    end

    // pending lv/select resets count sub-clock ticks; 2 ticks gives the 2-3 window
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I || lv_fire || sel_fire) begin
            lv_pending <= 1'b0;
            sel_pending <= 1'b0;
            sub_cnt <= 2'h0;
        end else begin
            // the supply must still be low one cycle past the full count, so a pulse of exactly QUAL_CYC is ignored
            if (qual_cnt == 8'(QUAL_CYC) && LV_LOW_SUPPLY_I && !POWERDOWN_I) begin
                lv_pending <= 1'b1;
            end
            if (!valid_sel) begin
                sel_pending <= 1'b1;
            end
            if ((lv_pending || sel_pending) && SUB_CLOCK_TICK_I) begin
                sub_cnt <= sub_cnt + 2'h1;
            end
        end
    end

    // ****************************************************
    // reset sequencer
    // ****************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            state <= MRC_DELAY;
            count <= 28'(POR_CYC);
            por_done <= 1'b0;
            pin_held <= 1'b0;
        end else begin
            case (state)
                MRC_RUN: begin
                    if (pin_low) begin
                        state <= MRC_HOLD;
                    end else if (lv_fire || sel_fire) begin
                        state <= MRC_DELAY;
                        count <= 28'(POR_CYC);
                    end else if (wdt_run) begin
                        state <= MRC_DELAY;
                        count <= 28'(PIN_CYC);
                    end else if (wdt_sleep) begin
                        state <= MRC_DELAY;
                        count <= sst_cycles(cfg[3:1]);
                    end
                end
                MRC_HOLD: begin
                    if (!pin_low) begin
                        state <= MRC_DELAY;
                        count <= 28'(PIN_CYC);
                    end
                end
                MRC_DELAY: begin
                    if (pin_low) begin
                        state <= MRC_HOLD;
                    end else if (count <= 28'h1) begin
                        state <= MRC_RUN;
                        por_done <= 1'b1;
                    end else begin
                        count <= count - 28'h1;
                    end
                end
                default: state <= MRC_RUN;
            endcase
            pin_held <= pin_low;
        end
    end

    // ****************************************************
    // outputs toward the core
    // ****************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            CORE_RESET_O <= 1'b1;
            FULL_RESET_O <= 1'b1;
            PC_SP_CLEAR_O <= 1'b1;
            POR_INIT_O <= 1'b1;
            PORT_INIT_O <= PORT_RESET;
        end else begin
            // the sleep wake keeps state, so only pc and sp are cleared
            CORE_RESET_O <= (state != MRC_RUN) || pin_low || lv_fire || sel_fire || wdt_run || wdt_sleep;
            FULL_RESET_O <= pin_low || lv_fire || sel_fire || wdt_run || state == MRC_HOLD;
            PC_SP_CLEAR_O <= wdt_sleep || pin_low || lv_fire || sel_fire || wdt_run;
            POR_INIT_O <= !por_done && state != MRC_RUN;
            PORT_INIT_O <= PORT_RESET;
        end
    end

    // ****************************************************
    // flags and registers
    // ****************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            WATCHDOG_TIMEOUT_FLAG_O <= 1'b0;
            POWERDOWN_FLAG_O <= 1'b0;
        end else if (wdt_run) begin
            WATCHDOG_TIMEOUT_FLAG_O <= 1'b1;
        end else if (wdt_sleep) begin
            WATCHDOG_TIMEOUT_FLAG_O <= 1'b1;
            POWERDOWN_FLAG_O <= 1'b1;
        end
    end

    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            lv_level_select <= LVL_SEL_RESET;
        end else if (sel_fire) begin
            lv_level_select <= LVL_SEL_RESET;
        end else if (wr && PADDR_I == LVL_SEL_ADDR) begin
            lv_level_select <= PWDATA_I[7:0];
        end
    end

    // hardware set wins over a software clear in the same cycle
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            flags <= 8'h00;
            cfg <= 4'h1;
        end else begin
            if (wr && PADDR_I == RST_FLAGS_ADDR) begin
                flags[FLAG_SYSCLK_ON] <= PWDATA_I[FLAG_SYSCLK_ON];
                for (int i = 0; i < 3; i++) begin
                    if (!PWDATA_I[i]) begin
                        flags[i] <= 1'b0;
                    end
                end
            end
            if (lv_fire) begin
                flags[FLAG_LV_CAUSE] <= 1'b1;
            end
            if (sel_pending || !valid_sel) begin
                flags[FLAG_SEL_FAULT] <= 1'b1;
            end
            if (WDT_CTRL_FAULT_I) begin
                flags[FLAG_WDT_FAULT] <= 1'b1;
            end
            if (wr && PADDR_I == CONFIG_ADDR) begin
                cfg <= PWDATA_I[3:0];
            end
        end
    end

    // ****************************************************
    // apb slave, zero wait states
    // ****************************************************
    always_ff @(posedge CLK_SYS_I) begin
        if (RST_I) begin
            PRDATA_O <= 32'h0;
            PREADY_O <= 1'b0;
            PSLVERR_O <= 1'b0;
            LV_LEVEL_SELECT_O <= LVL_SEL_RESET;
            EXT_RESET_PIN_IS_IO_O <= 1'b0;
        end else begin
            PREADY_O <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= PSEL_I && !PENABLE_I && !(PADDR_I == LVL_SEL_ADDR || PADDR_I == RST_FLAGS_ADDR
                || PADDR_I == STATUS_ADDR || PADDR_I == CONFIG_ADDR);
            LV_LEVEL_SELECT_O <= lv_level_select;
            EXT_RESET_PIN_IS_IO_O <= !cfg[CFG_PIN_RESET_EN];
            if (rd && !PENABLE_I) begin
                case (PADDR_I)
                    LVL_SEL_ADDR: PRDATA_O <= {24'h0, lv_level_select};
                    RST_FLAGS_ADDR: PRDATA_O <= {24'h0, flags[7], 4'h0, flags[2:0]};
                    STATUS_ADDR: PRDATA_O <= {28'h0, pin_held, POWERDOWN_FLAG_O, WATCHDOG_TIMEOUT_FLAG_O,
                        state == MRC_RUN};
                    CONFIG_ADDR: PRDATA_O <= {28'h0, cfg};
                    default: PRDATA_O <= 32'h0;
                endcase
            end
        end
    end

    // ****************************************************
    // checks
    // ****************************************************
    sel_restore_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        sel_fire |=> lv_level_select == LVL_SEL_RESET) else $error("level select not restored");
    lv_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        lv_fire |=> flags[FLAG_LV_CAUSE]) else $error("lv cause flag not set");
    lv_keep_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        lv_fire && !wr |=> $stable(lv_level_select)) else $error("level select changed");
    pin_hold_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        pin_low |=> ##1 CORE_RESET_O) else $error("core not held by pin");
    pin_opt_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        !cfg[CFG_PIN_RESET_EN] && state == MRC_RUN |=> state != MRC_HOLD) else $error("pin reset unselected");
    wdt_run_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        wdt_run && !pin_low && !lv_fire && !sel_fire |=> count == 28'(PIN_CYC)) else $error("bad delay");
    wdt_flag_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        wdt_sleep |=> WATCHDOG_TIMEOUT_FLAG_O && POWERDOWN_FLAG_O) else $error("flags not set");
    pd_lv_a: assert property (@(posedge CLK_SYS_I) disable iff (RST_I)
        POWERDOWN_I |=> qual_cnt == 8'h00) else $error("supervisor active in power-down");
endmodule : mrc_reset_ctrl
`default_nettype wire

// >>> tb/mrc_supply_model.sv
// reset pin and supply monitor model facing the reset controller
`timescale 1ns/100ps
`default_nettype none
module mrc_supply_model (
    // bench controls
    input wire logic clk_i,
    input wire logic press_i,
    input wire logic sag_i,
    // towards the controller
    output logic pin_n_o,
    output logic low_supply_o,
    output logic sub_tick_o
);
    logic [2:0] div = 3'h0;
    // the pin has a pull-up, so a released button reads high
    assign pin_n_o = !press_i;
    assign low_supply_o = sag_i;
    always_ff @(posedge clk_i) begin
        div <= div + 3'h1;
    end
    // sub clock far slower than the system clock: one tick in eight
    assign sub_tick_o = (div == 3'h7);
endmodule : mrc_supply_model
`default_nettype wire

// >>> tb/mrc_reset_ctrl_test.sv
// self-checking bench for the reset controller
`timescale 1ns/100ps
`default_nettype none
module mrc_reset_ctrl_test
    import mrc_pkg::*;
;
    // ****************************************************
    // bench
    // ****************************************************
    localparam int POR_T = 50;
    localparam int PIN_T = 20;
    localparam int QUAL_T = 8;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic press = 1'b0;
    logic sag = 1'b0;
    logic wdt = 1'b0;
    logic wfault = 1'b0;
    logic pdown = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, core_rst, pcsp, por_init, to_flag, pd_flag, is_io, pin_n, low_sup, tick;
    logic full;
    logic [7:0] port_init, lvl;
    int failures = 0;
    int n_tests = 0;
    int n;
    logic [31:0] r;
    logic e;
    mrc_supply_model sup_u (.clk_i(clk), .press_i(press), .sag_i(sag), .pin_n_o(pin_n),
        .low_supply_o(low_sup), .sub_tick_o(tick));
    mrc_reset_ctrl #(.POR_CYC(POR_T), .PIN_CYC(PIN_T), .QUAL_CYC(QUAL_T)) dut_u (
        .CLK_SYS_I(clk), .RST_I(rst), .EXT_RESET_PIN_N_I(pin_n), .LV_LOW_SUPPLY_I(low_sup),
        .WDT_TIMEOUT_I(wdt), .WDT_CTRL_FAULT_I(wfault), .SUB_CLOCK_TICK_I(tick),
        .POWERDOWN_I(pdown), .IDLE_I(1'b0), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .CORE_RESET_O(core_rst), .FULL_RESET_O(full),
        .PC_SP_CLEAR_O(pcsp), .POR_INIT_O(por_init), .PORT_INIT_O(port_init),
        .WATCHDOG_TIMEOUT_FLAG_O(to_flag), .POWERDOWN_FLAG_O(pd_flag),
        .LV_LEVEL_SELECT_O(lvl), .EXT_RESET_PIN_IS_IO_O(is_io));
    initial begin
        forever #2 clk = ~clk;
    end
    task automatic close_out();
        $display("compares %0d mismatches %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            failures++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one apb transfer, held until pready is seen at a rising edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            failures++;
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // counts edges until the core reset reaches a level, bounded
    task automatic wait_core(input logic lv);
        n = 0;
        while (core_rst !== lv && n < 3000) begin
            @(posedge clk);
            n++;
        end
    endtask : wait_core
    task automatic pulse_wdt();
        @(posedge clk) wdt <= 1'b1;
        @(posedge clk) wdt <= 1'b0;
    endtask : pulse_wdt
    // ****************************************************
    // scenarios
    // ****************************************************
    task automatic t_por();
        chk(core_rst, 1'b1);
        chk(por_init, 1'b1);
        chk(port_init, PORT_RESET);
        chk({to_flag, pd_flag}, 2'b00);
        wait_core(1'b0);
        chk(n >= POR_T - 2 && n <= POR_T + 8, 1);
        chk(por_init, 1'b0);
        apb(1'b0, LVL_SEL_ADDR, 32'h0);
        chk(r, 32'h55);
        apb(1'b0, RST_FLAGS_ADDR, 32'h0);
        chk(r, 32'h0);
        $display("power-on test done");
    endtask : t_por
    task automatic t_levels();
        logic [7:0] v[4];
        v = '{LVL_2V10, LVL_2V55, LVL_3V15, LVL_3V80};
        foreach (v[i]) begin
            apb(1'b1, LVL_SEL_ADDR, {24'h0, v[i]});
            apb(1'b0, LVL_SEL_ADDR, 32'h0);
            chk(r, {24'h0, v[i]});
            chk(core_rst, 1'b0);
        end
        apb(1'b0, 8'h10, 32'h0);
        chk({e, r}, {1'b1, 32'h0});
        apb(1'b1, LVL_SEL_ADDR, 32'h12);
        wait_core(1'b1);
        chk(n <= 32, 1);
        @(posedge clk);
        chk(lvl, 8'h55);
        wait_core(1'b0);
        apb(1'b0, RST_FLAGS_ADDR, 32'h0);
        chk(r[FLAG_SEL_FAULT], 1'b1);
        apb(1'b1, RST_FLAGS_ADDR, 32'h0);
        apb(1'b0, RST_FLAGS_ADDR, 32'h0);
        chk(r, 32'h0);
        $display("level select test done");
    endtask : t_levels
    task automatic t_pin();
        @(posedge clk) press <= 1'b1;
        wait_core(1'b1);
        chk(n <= 4, 1);
        chk(full, 1'b1);
        repeat (30) @(posedge clk);
        chk(core_rst, 1'b1);
        press <= 1'b0;
        wait_core(1'b0);
        chk(n >= PIN_T - 2 && n <= PIN_T + 8, 1);
        chk(to_flag, 1'b0);
        apb(1'b1, CONFIG_ADDR, 32'h0);
        repeat (2) @(posedge clk);
        chk(is_io, 1'b1);
        press <= 1'b1;
        repeat (30) @(posedge clk);
        chk(core_rst, 1'b0);
        press <= 1'b0;
        apb(1'b1, CONFIG_ADDR, 32'h1);
        $display("pin test done");
    endtask : t_pin
    task automatic t_lv();
        apb(1'b1, LVL_SEL_ADDR, {24'h0, LVL_2V55});
        sag <= 1'b1;
        repeat (QUAL_T) @(posedge clk);
        sag <= 1'b0;
        repeat (40) @(posedge clk);
        chk(core_rst, 1'b0);
        sag <= 1'b1;
        wait_core(1'b1);
        chk(n <= QUAL_T + 34, 1);
        sag <= 1'b0;
        chk(lvl, LVL_2V55);
        wait_core(1'b0);
        chk(n >= POR_T - 2, 1);
        apb(1'b0, RST_FLAGS_ADDR, 32'h0);
        chk(r[FLAG_LV_CAUSE], 1'b1);
        $display("supervisor test done");
    endtask : t_lv
    task automatic t_wdt();
        logic seen;
        pulse_wdt();
        wait_core(1'b1);
        chk(n <= 4, 1);
        wait_core(1'b0);
        chk(n >= PIN_T - 2 && n <= PIN_T + 8, 1);
        chk({to_flag, pd_flag}, 2'b10);
        pdown <= 1'b1;
        sag <= 1'b1;
        repeat (QUAL_T + 40) @(posedge clk);
        chk(core_rst, 1'b0);
        sag <= 1'b0;
        pulse_wdt();
        seen = 1'b0;
        repeat (4) @(posedge clk) seen |= (pcsp === 1'b1);
        chk(seen, 1'b1);
        chk({to_flag, pd_flag}, 2'b11);
        wait_core(1'b0);
        chk(n >= SST_RC_CYC - 6 && n <= SST_RC_CYC + 4, 1);
        pdown <= 1'b0;
        @(posedge clk) wfault <= 1'b1;
        @(posedge clk) wfault <= 1'b0;
        repeat (40) @(posedge clk);
        apb(1'b0, RST_FLAGS_ADDR, 32'h0);
        chk(r[FLAG_WDT_FAULT], 1'b1);
        $display("watchdog test done");
    endtask : t_wdt
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_por();
        t_levels();
        t_pin();
        t_lv();
        t_wdt();
        close_out();
    end
    // the tests need several hundred cycles; reaching the 50000-cycle limit means a hang
    initial begin
        #200000;
        failures++;
        close_out();
    end
endmodule : mrc_reset_ctrl_test
`default_nettype wire
